// ===== hdl/ulms_pkg.sv
// Purpose: Shared constants and carriers for the line and modem status block.
// Assumes: One 100 MHz clock, synchronous active-high reset.
// Notes: Offsets are the three-bit register addresses of the UART bus.
package ulms_pkg;
	localparam logic [2:0] ADDR_DIV_LOW = 3'h0;
	localparam logic [2:0] ADDR_DIV_HIGH = 3'h1;
	localparam logic [2:0] ADDR_LINE_STATUS = 3'h5;
	localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
	localparam logic [2:0] ADDR_SCRATCH = 3'h7;
	localparam logic [7:0] SCRATCH_RESET = 8'h00;
	localparam logic [7:0] DIVISOR_RESET = 8'h00;
	localparam logic [3:0] MODEM_IN_RESET = 4'h0;
	// Line status field positions.
	localparam int LS_DR = 0;
	localparam int LS_OE = 1;
	localparam int LS_PE = 2;
	localparam int LS_FE = 3;
	localparam int LS_BI = 4;
	localparam int LS_TX_HOLDING_EMPTY = 5;
	localparam int LS_TEMT = 6;
	// Modem control field positions.
	localparam int MC_TERM_READY = 0;
	localparam int MC_REQ_SEND = 1;
	localparam int MC_PROC_RESET = 2;
	localparam int MC_INT_ENABLE = 3;
	localparam int MC_LOOP = 4;
	// Character events from the receiver.
	typedef struct packed {
		logic char_done;
		logic parity_bad;
		logic stop_bad;
		logic break_word;
		logic break_two_words;
		logic from_modem_psk;
	} ulms_rx_evt_t;
	// Modem inputs in order clear, set ready, ring, carrier (true sense).
	typedef struct packed {
		logic carrier;
		logic ring;
		logic set_ready;
		logic clear_send;
	} ulms_modem_in_t;
endpackage : ulms_pkg

// ===== hdl/ulms_modem_status.sv
// Purpose: Modem input selection, delta flags and status byte.
// Assumes: Pins already synchronised by the caller.
// Notes: Delta set wins over a clear in the same cycle.
`timescale 1ns/1ps
module ulms_modem_status (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Sources
	input wire logic standalone_select,
	input wire ulms_pkg::ulms_modem_in_t ctrl_bits,
	input wire ulms_pkg::ulms_modem_in_t pins_n,
	input wire logic [7:0] modem_control,
	// Read strobe and result
	input wire logic status_read,
	output logic [7:0] status_byte
);
	ulms_pkg::ulms_modem_in_t sel_in;
	ulms_pkg::ulms_modem_in_t loop_in;
	ulms_pkg::ulms_modem_in_t prev_reg;
	logic [3:0] delta_reg;
	logic [3:0] delta_next;
	logic [3:0] changed;
	assign loop_in.clear_send = modem_control[ulms_pkg::MC_REQ_SEND];
	assign loop_in.set_ready = modem_control[ulms_pkg::MC_TERM_READY];
	assign loop_in.ring = modem_control[ulms_pkg::MC_PROC_RESET];
	assign loop_in.carrier = modem_control[ulms_pkg::MC_INT_ENABLE];
	assign sel_in = modem_control[ulms_pkg::MC_LOOP] ? loop_in :
		(standalone_select ? ~pins_n : ctrl_bits);
	assign changed = 4'(sel_in ^ prev_reg);
	// A change seen during the read cycle stays pending after the read.
	assign delta_next = changed | (status_read ? 4'h0 : delta_reg);
	always_ff @(posedge clk) begin
		if (rst) begin
			prev_reg <= ulms_pkg::MODEM_IN_RESET;
			delta_reg <= 4'h0;
		end else begin
			prev_reg <= sel_in;
			delta_reg <= delta_next;
		end
	end
	assign status_byte = {4'(sel_in), delta_reg};
endmodule : ulms_modem_status

// ===== hdl/ulms_top.sv
// Purpose: Line status, modem status, shared scratch and divisor decode.
// Assumes: Receiver, transmitter and control registers live elsewhere.
// Notes: Reads are answered one cycle after the strobe, from a flop.
// Operation
// - Set data ready on buffered character
// - Clear data ready on buffer read/zero-write
// - Flag overrun; clear on status read
// - Flag parity error; clear on status read
// - Flag framing error; clear on status read
// - No framing error on modem PSK path
// - Flag break after one zero word
// - PSK path needs two zero words
// - Holding empty until processor loads character
// - Fully empty when both registers empty
// - Standalone select picks control bits or pins
// - Clear-send and set-ready change flags
// - Ring change flag
// - Carrier change flag
// - Upper bits show the selected modem inputs; only the pins are complemented
// - Loopback takes inputs from control bits
// - Modem status ignores writes
// - Scratch reachable from both buses
// - Last scratch write wins
// - Divisor bytes only with access bit
// - Decode status and scratch addresses
`timescale 1ns/1ps
module ulms_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// UART bus (wide_reg_address top bit must be zero to select)
	input wire logic [3:0] wide_reg_address,
	input wire logic bus_rd,
	input wire logic bus_wr,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	// Modem controller bus to the scratch register
	input wire logic modem_scr_rd,
	input wire logic modem_scr_wr,
	input wire logic [7:0] modem_scr_wdata,
	output logic [7:0] modem_scr_rdata,
	// Joined blocks
	input wire logic divisor_access_bit,
	input wire logic [7:0] modem_control,
	input wire logic standalone_select,
	input wire ulms_pkg::ulms_modem_in_t ctrl_modem_bits,
	input wire ulms_pkg::ulms_modem_in_t modem_pins_n,
	input wire ulms_pkg::ulms_rx_evt_t rx_evt,
	input wire logic rx_buf_read,
	input wire logic rx_buf_zero_write,
	input wire logic tx_load,
	input wire logic tx_hold_free,
	input wire logic tx_shift_empty,
	// Results
	output logic [7:0] line_status,
	output logic [7:0] baud_divisor_low,
	output logic [7:0] baud_divisor_high,
	output logic [7:0] modem_input_status
);
	ulms_pkg::ulms_modem_in_t pins_meta_reg;
	ulms_pkg::ulms_modem_in_t pins_sync_reg;
	logic [7:0] ms_byte;
	logic rx_data_available;
	logic overrun_reg;
	logic rx_parity_error_flag;
	logic rx_framing_error_flag;
	logic rx_break_flag;
	logic tx_holding_empty;
	logic tx_fully_empty;
	logic [7:0] shared_scratch;
	logic [7:0] ls_byte;
	logic [7:0] rd_mux;
	logic sel_low;
	logic sel_div_low;
	logic sel_div_high;
	logic sel_ls;
	logic sel_ms;
	logic sel_scr;
	logic ls_read;
	logic ms_read;
	logic framing_set;
	logic break_set;

	// Pins come from outside the clock domain.
	always_ff @(posedge clk) begin
		if (rst) begin
			pins_meta_reg <= ulms_pkg::MODEM_IN_RESET;
			pins_sync_reg <= ulms_pkg::MODEM_IN_RESET;
		end else begin
			pins_meta_reg <= modem_pins_n;
			pins_sync_reg <= pins_meta_reg;
		end
	end

	// Address decode on the low three bits; wide form needs bit 3 clear.
	assign sel_low = (wide_reg_address[3] == 1'b0);
	assign sel_div_low = sel_low && divisor_access_bit &&
		(wide_reg_address[2:0] == ulms_pkg::ADDR_DIV_LOW);
	assign sel_div_high = sel_low && divisor_access_bit &&
		(wide_reg_address[2:0] == ulms_pkg::ADDR_DIV_HIGH);
	assign sel_ls = sel_low &&
		(wide_reg_address[2:0] == ulms_pkg::ADDR_LINE_STATUS);
	assign sel_ms = sel_low &&
		(wide_reg_address[2:0] == ulms_pkg::ADDR_MODEM_STATUS);
	assign sel_scr = sel_low &&
		(wide_reg_address[2:0] == ulms_pkg::ADDR_SCRATCH);
	assign ls_read = bus_rd && sel_ls;
	assign ms_read = bus_rd && sel_ms;

	// PSK data never shows a framing error and needs two zero words.
	assign framing_set = rx_evt.char_done && rx_evt.stop_bad &&
		!rx_evt.from_modem_psk;
	assign break_set = rx_evt.from_modem_psk ? rx_evt.break_two_words :
		rx_evt.break_word;

	ulms_modem_status u_modem_status (
		.clk(clk),
		.rst(rst),
		.standalone_select(standalone_select),
		.ctrl_bits(ctrl_modem_bits),
		.pins_n(pins_sync_reg),
		.modem_control(modem_control),
		.status_read(ms_read),
		.status_byte(ms_byte)
	);

	// Line status flags: a set in the cycle of the read survives.
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_data_available <= 1'b0;
			overrun_reg <= 1'b0;
			rx_parity_error_flag <= 1'b0;
			rx_framing_error_flag <= 1'b0;
			rx_break_flag <= 1'b0;
		end else begin
			rx_data_available <= rx_evt.char_done ||
				(rx_data_available && !rx_buf_read &&
				!rx_buf_zero_write);
			overrun_reg <= (rx_evt.char_done && rx_data_available &&
				!rx_buf_read) || (overrun_reg && !ls_read);
			rx_parity_error_flag <= (rx_evt.char_done && rx_evt.parity_bad) ||
				(rx_parity_error_flag && !ls_read);
			rx_framing_error_flag <= framing_set ||
				(rx_framing_error_flag && !ls_read);
			rx_break_flag <= break_set || (rx_break_flag && !ls_read);
		end
	end

	// Transmit flags follow the transmitter, with a load clearing at once.
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_holding_empty <= 1'b1;
			tx_fully_empty <= 1'b1;
		end else begin
			tx_holding_empty <= tx_hold_free && !tx_load;
			tx_fully_empty <= tx_hold_free && tx_shift_empty &&
				!tx_load;
		end
	end

	assign ls_byte = {1'b0, tx_fully_empty, tx_holding_empty, rx_break_flag,
		rx_framing_error_flag, rx_parity_error_flag, overrun_reg,
		rx_data_available};

	// Scratch: the UART bus wins a same-cycle clash, a fixed choice.
	always_ff @(posedge clk) begin
		if (rst) begin
			shared_scratch <= ulms_pkg::SCRATCH_RESET;
		end else if (bus_wr && sel_scr) begin
			shared_scratch <= bus_wdata;
		end else if (modem_scr_wr) begin
			shared_scratch <= modem_scr_wdata;
		end
	end

	// Divisor bytes; writes to modem status fall through unused.
	always_ff @(posedge clk) begin
		if (rst) begin
			baud_divisor_low <= ulms_pkg::DIVISOR_RESET;
			baud_divisor_high <= ulms_pkg::DIVISOR_RESET;
		end else begin
			if (bus_wr && sel_div_low) begin
				baud_divisor_low <= bus_wdata;
			end
			if (bus_wr && sel_div_high) begin
				baud_divisor_high <= bus_wdata;
			end
		end
	end

	assign rd_mux = sel_ls ? ls_byte : (sel_ms ? ms_byte :
		(sel_scr ? shared_scratch : 8'h00));

	always_ff @(posedge clk) begin
		if (rst) begin
			bus_rdata <= 8'h00;
			modem_scr_rdata <= 8'h00;
			line_status <= 8'h00;
			modem_input_status <= 8'h00;
		end else begin
			bus_rdata <= bus_rd ? rd_mux : 8'h00;
			modem_scr_rdata <= modem_scr_rd ? shared_scratch : 8'h00;
			line_status <= ls_byte;
			modem_input_status <= ms_byte;
		end
	end

	ls_bit7_a: assert property (@(posedge clk) disable iff (rst)
		line_status[7] == 1'b0) else $error("line status bit 7 set");
	dr_set_a: assert property (@(posedge clk) disable iff (rst)
		rx_evt.char_done |=> rx_data_available)
		else $error("data ready not set");
	dr_clear_a: assert property (@(posedge clk) disable iff (rst)
		(rx_buf_read && !rx_evt.char_done) |=> !rx_data_available)
		else $error("data ready not cleared");
	oe_clear_a: assert property (@(posedge clk) disable iff (rst)
		(ls_read && !rx_evt.char_done) |=> !overrun_reg)
		else $error("overrun not cleared");
	pe_clear_a: assert property (@(posedge clk) disable iff (rst)
		(ls_read && !rx_evt.char_done) |=> !rx_parity_error_flag)
		else $error("parity flag not cleared");
	fe_psk_a: assert property (@(posedge clk) disable iff (rst)
		(rx_evt.from_modem_psk && ls_read) |=> !rx_framing_error_flag)
		else $error("framing error on psk path");
	brk_psk_a: assert property (@(posedge clk) disable iff (rst)
		(rx_evt.from_modem_psk && !rx_evt.break_two_words && ls_read)
		|=> !rx_break_flag)
		else $error("psk break without two words");
	tx_holding_empty_load_a: assert property (@(posedge clk) disable iff (rst)
		tx_load |=> !tx_holding_empty ##1 1'b1)
		else $error("holding empty after load");
	temt_a: assert property (@(posedge clk) disable iff (rst)
		tx_fully_empty |-> $past(tx_shift_empty))
		else $error("fully empty with shift busy");
	scr_last_a: assert property (@(posedge clk) disable iff (rst)
		(modem_scr_wr && !(bus_wr && sel_scr)) |=>
		shared_scratch == $past(modem_scr_wdata))
		else $error("scratch lost modem write");
	div_guard_a: assert property (@(posedge clk) disable iff (rst)
		!divisor_access_bit |=> $stable(baud_divisor_low))
		else $error("divisor written without access bit");
	loop_cts_a: assert property (@(posedge clk) disable iff (rst)
		modem_control[4] |-> ms_byte[4] == modem_control[1])
		else $error("loopback clear-send wrong");
	ms_delta_a: assert property (@(posedge clk) disable iff (rst)
		(ms_read && $stable(ms_byte[7:4])) |=> ms_byte[3:0] == 4'h0)
		else $error("delta flags not cleared");

	ls_cover_c: cover property (@(posedge clk) disable iff (rst)
		rx_evt.char_done ##1 ls_read);
	ovr_cover_c: cover property (@(posedge clk) disable iff (rst)
		overrun_reg);
	scr_cover_c: cover property (@(posedge clk) disable iff (rst)
		modem_scr_wr ##1 bus_rd && sel_scr);
	loop_cover_c: cover property (@(posedge clk) disable iff (rst)
		modem_control[4] && ms_byte[0]);
endmodule : ulms_top

// ===== verif/ulms_modem_ctl_model.sv
// Purpose: Modem controller side of the shared scratch register.
// Assumes: Strobes change on the falling edge and last one cycle.
// Notes: Released write data is inverted so a stale value never matches.
`timescale 1ns/1ps
module ulms_modem_ctl_model (
	// Clock
	input wire logic clk,
	// Modem bus
	output logic modem_scr_rd,
	output logic modem_scr_wr,
	output logic [7:0] modem_scr_wdata
);
	initial begin
		modem_scr_rd = 1'b0;
		modem_scr_wr = 1'b0;
		modem_scr_wdata = 8'h00;
	end
	task automatic scr_write(input logic [7:0] d);
		@(negedge clk);
		modem_scr_wr = 1'b1;
		modem_scr_wdata = d;
		@(negedge clk);
		modem_scr_wr = 1'b0;
		modem_scr_wdata = ~d;
	endtask : scr_write
	task automatic scr_read();
		@(negedge clk);
		modem_scr_rd = 1'b1;
		@(negedge clk);
		modem_scr_rd = 1'b0;
	endtask : scr_read
endmodule : ulms_modem_ctl_model

// ===== verif/tb_top.sv
// Purpose: Self-checking bench for the line and modem status block.
// Assumes: Inputs change on the falling edge of a 100 MHz clock.
// Notes: Read results are queued by the driver and checked by a watcher.
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic bus_rd = 1'b0;
	logic bus_wr = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] bus_rdata, mrdata, dl, dh, ls, ms, mwdata;
	logic mrd, mwr;
	logic dab = 1'b0;
	logic [7:0] mc = 8'h00;
	logic sa = 1'b0;
	ulms_pkg::ulms_modem_in_t ctrl = 4'h0;
	ulms_pkg::ulms_modem_in_t pins = 4'hF;
	ulms_pkg::ulms_rx_evt_t evt = 6'h00;
	logic bread = 1'b0;
	logic bzero = 1'b0;
	logic hfree = 1'b1;
	logic tload = 1'b0;
	logic sempty = 1'b1;
	logic rd_d = 1'b0;
	logic mrd_d = 1'b0;
	logic [7:0] q[$];
	logic [7:0] mq[$];
	logic [3:0] cur = 4'h0;
	int errors = 0;
	int n_tests = 0;
	int seed = 61;
	int i;
	always #5 clk = ~clk;
	ulms_top u_dut (.clk(clk), .rst(rst), .wide_reg_address(addr),
		.bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(wdata),
		.bus_rdata(bus_rdata), .modem_scr_rd(mrd), .modem_scr_wr(mwr),
		.modem_scr_wdata(mwdata), .modem_scr_rdata(mrdata),
		.divisor_access_bit(dab), .modem_control(mc),
		.standalone_select(sa), .ctrl_modem_bits(ctrl),
		.modem_pins_n(pins), .rx_evt(evt), .rx_buf_read(bread),
		.rx_buf_zero_write(bzero), .tx_load(tload), .tx_hold_free(hfree),
		.tx_shift_empty(sempty), .line_status(ls), .baud_divisor_low(dl),
		.baud_divisor_high(dh), .modem_input_status(ms));
	ulms_modem_ctl_model u_mdm (.clk(clk), .modem_scr_rd(mrd),
		.modem_scr_wr(mwr), .modem_scr_wdata(mwdata));
	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude
	task automatic hw(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		bus_wr = 1'b1;
		@(negedge clk);
		bus_wr = 1'b0;
	endtask : hw
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		bus_rd = 1'b1;
		q.push_back(e);
		@(negedge clk);
		bus_rd = 1'b0;
	endtask : rd
	task automatic ev(input ulms_pkg::ulms_rx_evt_t e);
		@(negedge clk);
		evt = e;
		@(negedge clk);
		evt = 6'h00;
	endtask : ev
	// Four cycles cover the pin synchroniser plus the registered copy.
	task automatic mstep(input logic [3:0] v);
		logic [3:0] old;
		old = cur;
		cur = v;
		repeat (4) @(negedge clk);
		rd(4'h6, {v, old ^ v});
		rd(4'h6, {v, 4'h0});
	endtask : mstep
	always @(posedge clk) begin
		rd_d <= bus_rd;
		mrd_d <= mrd;
	end
	always @(negedge clk) begin
		if (rd_d && q.size() > 0) check("bus_rdata", bus_rdata, q.pop_front());
		if (mrd_d && mq.size() > 0) check("scr_rdata", mrdata, mq.pop_front());
	end
	initial begin
		repeat (50000) @(negedge clk);
		errors++;
		conclude();
	end
	initial begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		rd(4'h5, 8'h60);
		ev(6'h20);
		rd(4'h5, 8'h61);
		ev(6'h3C);
		rd(4'h5, 8'h7F);
		rd(4'h5, 8'h61);
		@(negedge clk);
		bread = 1'b1;
		@(negedge clk);
		bread = 1'b0;
		rd(4'h5, 8'h60);
		ev(6'h2D);
		rd(4'h5, 8'h61);
		rd(4'h5, 8'h61);
		@(negedge clk);
		bzero = 1'b1;
		@(negedge clk);
		bzero = 1'b0;
		ev(6'h23);
		rd(4'h5, 8'h71);
		@(negedge clk);
		bzero = 1'b1;
		hfree = 1'b0;
		@(negedge clk);
		bzero = 1'b0;
		rd(4'h5, 8'h00);
		hfree = 1'b1;
		sempty = 1'b0;
		rd(4'h5, 8'h20);
		sempty = 1'b1;
		tload = 1'b1;
		rd(4'h5, 8'h00);
		tload = 1'b0;
		rd(4'h5, 8'h60);
		rd(4'h6, 8'h00);
		for (i = 0; i < 4; i++) begin
			@(negedge clk);
			ctrl = 4'($random(seed));
			mstep(ctrl);
		end
		// Pins already match the control value, so the switch is no change.
		pins = ~cur;
		repeat (3) @(negedge clk);
		sa = 1'b1;
		for (i = 0; i < 4; i++) begin
			@(negedge clk);
			pins = 4'($random(seed));
			mstep(~pins);
		end
		for (i = 0; i < 4; i++) begin
			@(negedge clk);
			mc = {4'h1, 4'($random(seed))};
			mstep({mc[3], mc[2], mc[0], mc[1]});
		end
		hw(4'h6, 8'hFF);
		rd(4'h6, {cur, 4'h0});
		hw(4'h7, 8'h3C);
		mq.push_back(8'h3C);
		u_mdm.scr_read();
		u_mdm.scr_write(8'hC3);
		rd(4'h7, 8'hC3);
		fork
			hw(4'h7, 8'h11);
			u_mdm.scr_write(8'h22);
		join
		rd(4'h7, 8'h11);
		hw(4'h0, 8'hA5);
		hw(4'h1, 8'h5A);
		check("baud_divisor_low", dl, 8'h00);
		check("baud_divisor_high", dh, 8'h00);
		dab = 1'b1;
		hw(4'h0, 8'hA5);
		hw(4'h1, 8'h5A);
		@(negedge clk);
		check("baud_divisor_low", dl, 8'hA5);
		check("baud_divisor_high", dh, 8'h5A);
		dab = 1'b0;
		rd(4'hD, 8'h00);
		check("line_status", ls, 8'h60);
		check("modem_input_status", ms, {cur, 4'h0});
		for (i = 0; i < 10 && q.size() + mq.size() > 0; i++) @(negedge clk);
		if (q.size() + mq.size() > 0) errors++;
		conclude();
	end
endmodule : tb_top
